// file: hw/ibc_cycle_ctrl.sv
// Purpose: backplane cycle control, DMA/IRQ ranking, NMI, ROM select, resets
// Assumes: host-side inputs are on clk_i; backplane pins are asynchronous
// Notes: register port reads answer one cycle after the read strobe
`timescale 1ns/10ps
// How it works
// - clamp input forces address bit 20 low
// - NMI on unmasked parity, or on channel check while a cycle runs
// - bus size output limits CPU to 16 bits
// - hold request stays until master finishes
// - AEN with hold ack encodes cycle type
// - BALE low for idle, high when borrowed
// - DMA channel 0 highest; 5-7 wide
// - ready low inserts waits until high
// - 16-bit select inputs choose transfer width
// - I/O strobes driven, sampled in master
// - interrupt requests recognised on rising edge
// - rank 8 (RTC) first, then 9-15, then 3-7; RTC input active low
// - low address from byte enables, refresh
// - memory commands below 16 MB, master inputs
// - system memory commands below 1 MB only
// - oscillator divided by twelve for timer
// - zero wait input ends cycle early
// - keyboard reset requests warm reset
// - ROM select qualified by read unless configured
// - strap sampled at reset picks CPU mode
// - speaker is timer 2 gated by control
// - CPU reset on system, shutdown, keyboard, fast
module ibc_cycle_ctrl import ibc_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        cyc_start_i,
	input  wire logic        host_mem_i,
	input  wire logic        host_wr_i,
	input  wire logic [31:0] host_addr_i,
	input  wire logic [3:0]  host_byte_enables_n_i,
	input  wire logic        host_local_i,
	input  wire logic        host_hold_ack_i,
	input  wire logic        refresh_req_i,
	input  wire logic        shutdown_i,
	input  wire logic        timer2_out_i,
	input  wire logic        int_ack_i,
	input  wire logic        keyboard_addr20_clamp_n_i,
	input  wire logic        parity_n_i,
	input  wire logic        iochk_n_i,
	input  wire logic        iochrdy_i,
	input  wire logic        zero_wait_n_i,
	input  wire logic        iocs16_n_i,
	input  wire logic        memcs16_n_i,
	input  wire logic        master_n_i,
	input  wire logic        kbd_reset_req_n_i,
	input  wire logic        rtc_select_cpu_strap_i,
	input  wire logic        osc_i,
	input  wire logic        ior_n_i,
	input  wire logic        iow_n_i,
	input  wire logic        memr_n_i,
	input  wire logic        memw_n_i,
	input  wire logic [7:0]  drq_i,
	input  wire logic [15:9] irq_hi_i,
	input  wire logic [7:3]  irq_lo_i,
	input  wire logic        rtc_irq_n_i,
	output logic             ior_n_o,
	output logic             iow_n_o,
	output logic             memr_n_o,
	output logic             memw_n_o,
	output logic             cmd_oe_o,
	output logic             smemr_n_o,
	output logic             smemw_n_o,
	output logic      [19:0] sys_addr_o,
	output logic      [23:17] lat_addr_o,
	output logic             addr_oe_o,
	output logic             bale_o,
	output logic             aen_o,
	output logic             backplane_clk_o,
	output logic             bus_size_sixteen_n_o,
	output logic             hold_request_out_o,
	output logic      [7:0]  dack_n_o,
	output logic             dma_wide_o,
	output logic      [3:0]  master_cmd_o,
	output logic             cycle_done_o,
	output logic             cycle_wide_o,
	output logic             int_o,
	output logic      [3:0]  int_vec_o,
	output logic             nmi_o,
	output logic             cpu_reset_out_o,
	output logic             fpu_reset_out_o,
	output logic             bios_rom_select_o,
	output logic             speaker_out_o,
	output logic             timer_tick_o,
	output logic             cpu_mode_legacy_o
);
	typedef struct packed {
		logic [PIN_W-1:0] sy1;
		logic [PIN_W-1:0] sy2;
		logic        osc_d;
		logic [3:0]  div;
		logic        tick;
		logic        bclk;
		ibc_state_e  st;
		ibc_kind_e   kind;
		logic        wr;
		logic        lo1m;
		logic        lo16m;
		logic [3:0]  cnt;
		ibc_owner_e  own;
		logic [2:0]  dch;
		logic        hold;
		logic [7:0]  dack_n;
		logic        dwide;
		logic [15:0] irq_d;
		logic [15:0] pend;
		logic        intr;
		logic [3:0]  vec;
		logic        nmi;
		logic [7:0]  cfg;
		logic [7:0]  sc;
		logic [7:0]  nm;
		logic [3:0]  fr_cnt;
		logic        cpurst;
		logic [1:0]  por;
		logic        strap;
		logic [7:0]  rdata;
		logic [7:0]  ra;
		logic [19:0] sa;
		logic [6:0]  la;
		logic        bale;
		logic        aen;
		logic        ior_n;
		logic        iow_n;
		logic        memr_n;
		logic        memw_n;
		logic        smemr_n;
		logic        smemw_n;
		logic        bus_size_sixteen_n_n;
		logic        b16;
		logic        done;
		logic        rom;
		logic        spk;
		logic [3:0]  mcmd;
	} ibc_q_s;

	localparam ibc_q_s Q_RST = '{sy1: PIN_IDLE, sy2: PIN_IDLE, st: ST_IDLE, kind: K_IO, own: OW_CPU,
		dack_n: 8'hFF, cfg: CFG_RST, sc: SC_RST, nm: NM_RST, cpurst: 1'b1, por: 2'h3,
		ior_n: 1'b1, iow_n: 1'b1, memr_n: 1'b1, memw_n: 1'b1, smemr_n: 1'b1, smemw_n: 1'b1,
		bus_size_sixteen_n_n: 1'b1, default: '0};

	ibc_q_s q;
	ibc_q_s d;
	logic [PIN_W-1:0] s;
	logic [15:0]      irqv;
	logic [7:0]       drqv;
	logic [3:0]       dpick;
	logic [3:0]       ipick;
	logic             a20;

	// lowest set bit wins; both rankings reduce to this after reordering
	function automatic logic [3:0] ibc_pick(input logic [15:0] v);
		ibc_pick = 4'h0;
		for (int i = 15; i >= 0; i--) begin
			if (v[i])
				ibc_pick = 4'(i);
		end
	endfunction

	function automatic logic [1:0] ibc_be_lo(input logic [3:0] ben);
		if (!ben[0])
			ibc_be_lo = 2'h0;
		else if (!ben[1])
			ibc_be_lo = 2'h1;
		else if (!ben[2])
			ibc_be_lo = 2'h2;
		else
			ibc_be_lo = 2'h3;
	endfunction

	assign s = q.sy2;
	assign irqv = {s[P_IRQH+6:P_IRQH], ~s[P_RTC], s[P_IRQL+4:P_IRQL], 3'h0};
	assign drqv = s[P_DRQ+7:P_DRQ] & DRQ_USED;
	assign dpick = ibc_pick({8'h00, drqv});
	assign a20 = host_addr_i[20] & s[P_A20];

	always_comb begin
		d = q;
		d.sy1 = {rtc_irq_n_i, irq_lo_i, irq_hi_i, drq_i, memw_n_i, memr_n_i, iow_n_i, ior_n_i, osc_i,
			rtc_select_cpu_strap_i, kbd_reset_req_n_i, master_n_i, memcs16_n_i, iocs16_n_i,
			zero_wait_n_i, iochrdy_i, iochk_n_i, parity_n_i, keyboard_addr20_clamp_n_i};
		d.sy2 = q.sy1;
		d.bclk = ~q.bclk;
		d.done = 1'b0;
		d.rdata = 8'h00;
		// osc is faster than clk_i; edges closer than one period alias away
		d.osc_d = s[P_OSC];
		d.tick = 1'b0;
		if (s[P_OSC] && !q.osc_d) begin
			if (q.div == 4'(OSC_DIV - 1)) begin
				d.div = 4'h0;
				d.tick = 1'b1;
			end else begin
				d.div = q.div + 4'h1;
			end
		end
		if (reg_wr_i) begin
			case (reg_addr_i)
				REG_CFG: d.cfg = reg_wdata_i;
				REG_SYSCTL: d.sc = reg_wdata_i;
				REG_NMIMSK: d.nm = reg_wdata_i;
				REG_FASTRST: if (reg_wdata_i[FR_GO]) d.fr_cnt = 4'(FRST_CYC);
				default: ;
			endcase
		end
		if (reg_rd_i) begin
			case (reg_addr_i)
				REG_CFG: d.rdata = q.cfg;
				REG_SYSCTL: d.rdata = q.sc;
				REG_NMIMSK: d.rdata = q.nm;
				REG_STATUS: d.rdata = {q.strap, q.nmi, q.intr, q.hold, q.own, q.st};
				default: d.rdata = 8'h00;
			endcase
		end
		if (q.fr_cnt != 4'h0 && !(reg_wr_i && reg_addr_i == REG_FASTRST))
			d.fr_cnt = q.fr_cnt - 4'h1;
		d.cpurst = (d.fr_cnt != 4'h0) | ~s[P_KRST] | shutdown_i;
		// strap is read once the synchroniser holds a real pin value
		if (q.por != 2'h0)
			d.por = q.por - 2'h1;
		if (q.por == 2'h1)
			d.strap = s[P_STRAP];
		// interrupt capture: a new edge beats a simultaneous acknowledge
		d.irq_d = irqv;
		d.pend = q.pend & irqv;
		if (int_ack_i && q.intr)
			d.pend[q.vec] = 1'b0;
		d.pend = d.pend | (irqv & ~q.irq_d);
		ipick = ibc_pick({d.pend[7:0], d.pend[15:8]});
		d.vec = ipick + 4'h8;
		d.intr = |d.pend;
		d.nmi = (~s[P_PAR] & ~q.nm[NM_PAR]) | (~s[P_CHK] & (q.st != ST_IDLE));
		d.spk = timer2_out_i & q.sc[SC_SPK];
		// DMA arbitration
		case (q.own)
			OW_CPU: begin
				if (|drqv)
					d.hold = 1'b1;
				else
					d.hold = 1'b0;
				if (q.hold && host_hold_ack_i && q.st == ST_IDLE && |drqv) begin
					d.dch = dpick[2:0];
					d.dack_n = ~(8'h01 << dpick[2:0]);
					d.dwide = dpick[2:0] >= 3'h5;
					d.own = s[P_MST] ? OW_DMA : OW_MST;
				end
			end
			OW_DMA, OW_MST: begin
				if (!drqv[q.dch]) begin
					d.own = OW_CPU;
					d.hold = 1'b0;
					d.dack_n = 8'hFF;
				end else if (q.own == OW_DMA && !s[P_MST]) begin
					d.own = OW_MST;
				end
			end
			default: d.own = OW_CPU;
		endcase
		// cycle sequencer
		case (q.st)
			ST_IDLE: begin
				if (cyc_start_i && !host_local_i && q.own != OW_MST) begin
					d.st = ST_ADDR;
					d.kind = host_mem_i ? K_MEM : K_IO;
					d.wr = host_wr_i;
					d.lo16m = host_addr_i[31:24] == 8'h00;
					d.lo1m = d.lo16m && host_addr_i[23:21] == 3'h0 && !a20;
					d.sa = {host_addr_i[19:2], ibc_be_lo(host_byte_enables_n_i)};
					d.la = {host_addr_i[23:21], a20, host_addr_i[19:17]};
				end else if (refresh_req_i && q.own == OW_CPU && !q.hold) begin
					d.st = ST_ADDR;
					d.kind = K_REF;
					d.wr = 1'b0;
					d.lo16m = 1'b1;
					d.lo1m = 1'b1;
					d.sa = {12'h000, q.ra};
					d.la = 7'h00;
					d.ra = q.ra + 8'h01;
				end
			end
			ST_ADDR: begin
				d.st = ST_CMD;
				d.cnt = 4'(CMD_CYC - 1);
				d.ior_n = ~(q.kind == K_IO && !q.wr);
				d.iow_n = ~(q.kind == K_IO && q.wr);
				d.memr_n = ~((q.kind == K_MEM && !q.wr && q.lo16m) || q.kind == K_REF);
				d.memw_n = ~(q.kind == K_MEM && q.wr && q.lo16m);
				d.smemr_n = d.memr_n | ~q.lo1m;
				d.smemw_n = d.memw_n | ~q.lo1m;
			end
			ST_CMD: begin
				if (!s[P_ZWS] || (q.cnt == 4'h0 && s[P_RDY])) begin
					d.st = ST_DONE;
					d.b16 = (q.kind == K_IO) ? ~s[P_C16I] : ~s[P_C16M];
					{d.ior_n, d.iow_n, d.memr_n, d.memw_n, d.smemr_n, d.smemw_n} = 6'h3F;
				end else if (q.cnt != 4'h0) begin
					d.cnt = q.cnt - 4'h1;
				end
			end
			ST_DONE: begin
				d.st = ST_IDLE;
				d.done = 1'b1;
			end
			default: d.st = ST_IDLE;
		endcase
		// refresh cycles leave bus sizing to the card, host cycles in the sequencer are 16 bits
		d.bus_size_sixteen_n_n = ~(d.st != ST_IDLE && d.kind != K_REF);
		d.bale = (d.st == ST_ADDR) | (d.own != OW_CPU) | (d.st != ST_IDLE && d.kind == K_REF);
		d.aen = (d.own == OW_DMA) | (d.st != ST_IDLE && d.kind == K_REF);
		d.mcmd = (q.own == OW_MST) ? ~s[P_IOR+3:P_IOR] : 4'h0;
		d.rom = d.la[6:3] == 4'h0 && d.sa[19:16] == ROM_SEG && d.st != ST_IDLE && d.kind == K_MEM
			&& (q.cfg[CFG_ROMQ] || !d.memr_n);
	end

	always_ff @(posedge clk_i) begin
		if (reset_i)
			q <= Q_RST;
		else
			q <= d;
	end

	assign reg_rdata_o = q.rdata;
	assign ior_n_o = q.ior_n;
	assign iow_n_o = q.iow_n;
	assign memr_n_o = q.memr_n;
	assign memw_n_o = q.memw_n;
	assign cmd_oe_o = q.own != OW_MST;
	assign smemr_n_o = q.smemr_n;
	assign smemw_n_o = q.smemw_n;
	assign sys_addr_o = q.sa;
	assign lat_addr_o = q.la;
	assign addr_oe_o = q.own != OW_MST;
	assign bale_o = q.bale;
	assign aen_o = q.aen;
	assign backplane_clk_o = q.bclk;
	assign bus_size_sixteen_n_o = q.bus_size_sixteen_n_n;
	assign hold_request_out_o = q.hold;
	assign dack_n_o = q.dack_n;
	assign dma_wide_o = q.dwide;
	assign master_cmd_o = q.mcmd;
	assign cycle_done_o = q.done;
	assign cycle_wide_o = q.b16;
	assign int_o = q.intr;
	assign int_vec_o = q.vec;
	assign nmi_o = q.nmi;
	assign cpu_reset_out_o = q.cpurst;
	assign fpu_reset_out_o = q.cpurst;
	assign bios_rom_select_o = q.rom;
	assign speaker_out_o = q.spk;
	assign timer_tick_o = q.tick;
	assign cpu_mode_legacy_o = q.strap;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	sequence s_cpu_start;
		q.st == ST_IDLE && cyc_start_i && !host_local_i && q.own != OW_MST;
	endsequence
	sequence s_stalled;
		q.st == ST_CMD && q.cnt == 4'h0 && s[P_ZWS] && !s[P_RDY];
	endsequence

	a20_clamp_a: assert property (s_cpu_start ##0 !s[P_A20] |=> !q.la[3])
		else $error("bit 20 passed while clamped");
	nmi_parity_a: assert property (!s[P_PAR] && !q.nm[NM_PAR] |=> nmi_o)
		else $error("open parity error gave no NMI");
	bus_size_a: assert property (s_cpu_start |=> !bus_size_sixteen_n_o [*3])
		else $error("bus size not held through cycle");
	hold_keep_a: assert property (q.own != OW_CPU && drqv[q.dch] |=> hold_request_out_o)
		else $error("hold dropped while master active");
	cycle_type_a: assert property (aen_o && q.own == OW_CPU |-> q.kind == K_REF && q.st != ST_IDLE)
		else $error("address enable outside refresh or DMA");
	bale_strobe_a: assert property (s_cpu_start |=> bale_o ##1 !bale_o)
		else $error("address latch not a single pulse");
	dma_rank_a: assert property (q.own == OW_CPU ##1 q.own != OW_CPU
		|-> (($past(drqv) & ((8'h01 << q.dch) - 8'h01)) == 8'h00) && dma_wide_o == (q.dch >= 3'h5))
		else $error("DMA grant not highest ranked");
	wait_ready_a: assert property (s_stalled |=> q.st == ST_CMD && !ior_n_o == (q.kind == K_IO && !q.wr))
		else $error("cycle ended while ready low");
	zero_wait_a: assert property (q.st == ST_CMD && !s[P_ZWS] |=> q.st == ST_DONE ##1 cycle_done_o)
		else $error("zero wait did not end cycle");
	local_iow_a: assert property (q.st == ST_IDLE && cyc_start_i && host_local_i |=> iow_n_o [*2])
		else $error("I/O write on local access");
	speaker_a: assert property (##1 speaker_out_o == $past(timer2_out_i && q.sc[SC_SPK]))
		else $error("speaker gating wrong");
	smem_a: assert property (!smemr_n_o |-> !memr_n_o && q.lo1m)
		else $error("system read above 1 MB");
endmodule // ibc_cycle_ctrl

// file: shared/ibc_pkg.sv
// Purpose: constants and types for the backplane cycle control block
// Assumes: 10 MHz host clock, 8-bit register port
// Notes: pin vector indexes describe the order of the synchronised pin bundle
package ibc_pkg;
	localparam int CLK_MHZ = 10;
	localparam logic [7:0] REG_CFG     = 8'h07;
	localparam logic [7:0] REG_SYSCTL  = 8'h61;
	localparam logic [7:0] REG_NMIMSK  = 8'h70;
	localparam logic [7:0] REG_STATUS  = 8'h80;
	localparam logic [7:0] REG_FASTRST = 8'h92;
	localparam int CFG_ROMQ = 4;
	localparam int SC_SPK   = 1;
	localparam int NM_PAR   = 0;
	localparam int FR_GO    = 0;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] SC_RST  = 8'h00;
	localparam logic [7:0] NM_RST  = 8'h01;
	localparam int CMD_MIN_NS = 300;
	localparam int CMD_CYC    = (CMD_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int FRST_NS    = 1000;
	localparam int FRST_CYC   = (FRST_NS * CLK_MHZ + 999) / 1000;
	localparam int OSC_DIV    = 12;
	localparam logic [3:0] ROM_SEG  = 4'hF;
	localparam logic [7:0] DRQ_USED = 8'hEF;
	localparam int P_A20 = 0;
	localparam int P_PAR = 1;
	localparam int P_CHK = 2;
	localparam int P_RDY = 3;
	localparam int P_ZWS = 4;
	localparam int P_C16I = 5;
	localparam int P_C16M = 6;
	localparam int P_MST = 7;
	localparam int P_KRST = 8;
	localparam int P_STRAP = 9;
	localparam int P_OSC = 10;
	localparam int P_IOR = 11;
	localparam int P_DRQ = 15;
	localparam int P_IRQH = 23;
	localparam int P_IRQL = 30;
	localparam int P_RTC = 35;
	localparam int PIN_W = 36;
	localparam logic [35:0] PIN_IDLE = 36'h8000079FF;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ADDR = 2'b01, ST_CMD = 2'b11, ST_DONE = 2'b10} ibc_state_e;
	typedef enum logic [1:0] {OW_CPU = 2'b00, OW_DMA = 2'b01, OW_MST = 2'b11} ibc_owner_e;
	typedef enum logic [1:0] {K_IO = 2'b00, K_MEM = 2'b01, K_REF = 2'b10} ibc_kind_e;
endpackage

// file: bench/ibc_card.sv
// Purpose: backplane slave card answering the block's command strobes
// Assumes: strobes are the resolved wire levels, low while a command runs
// Notes: ready and select lines are pulled up, so a released line reads high
`timescale 1ns/10ps
module ibc_card (
	input  wire logic       clk_i,
	input  wire logic       ior_n_i,
	input  wire logic       iow_n_i,
	input  wire logic       memr_n_i,
	input  wire logic       memw_n_i,
	input  wire logic [7:0] wait_i,
	input  wire logic       wide_i,
	input  wire logic       fast_i,
	output logic            iochrdy_o,
	output logic            cs16_n_o,
	output logic            zws_n_o
);
	logic [7:0] cnt_q = 8'h00;
	logic       act;
	assign act = !(ior_n_i && iow_n_i && memr_n_i && memw_n_i);
	always_ff @(posedge clk_i) begin
		cnt_q <= act ? cnt_q + 8'h01 : 8'h00;
	end
	// a slow card holds ready low for wait_i cycles of each command
	assign iochrdy_o = !act || (cnt_q >= wait_i);
	assign cs16_n_o  = !(act && wide_i);
	assign zws_n_o   = !(act && fast_i);
endmodule // ibc_card

// file: bench/isa_backplane_cycle_control_tb.sv
// Purpose: self-checking bench for the backplane cycle control block
// Assumes: pins sync in two cycles; the card model answers backplane commands
// Notes: cycle shape is judged from which strobes and flags were seen low or high
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("[ERR] %0t value %h", $time, a); end end
`define WAIT(c) begin for (k = 0; k < 50 && !(c); k++) begin @(posedge clk_i); #1; end if (!(c)) timeout(); end
module isa_backplane_cycle_control_tb import ibc_pkg::*;;
	logic         clk_i = 1'b0, osc_i = 1'b0, shutdown_i = 1'b0;
	logic         reset_i, reg_wr_i, reg_rd_i, cyc_start_i, host_mem_i, host_wr_i, host_local_i, host_hold_ack_i;
	logic         refresh_req_i, timer2_out_i, int_ack_i, keyboard_addr20_clamp_n_i, parity_n_i, iochk_n_i;
	logic         master_n_i, kbd_reset_req_n_i, rtc_select_cpu_strap_i, rtc_irq_n_i, wide, fast;
	logic [7:0]   reg_addr_i, reg_wdata_i, drq_i, wait_n, reg_rdata_o, dack_n_o;
	logic [31:0]  host_addr_i;
	logic [3:0]   host_byte_enables_n_i = 4'hB;
	logic [15:9]  irq_hi_i;
	logic [7:3]   irq_lo_i;
	logic         ior_n_o, iow_n_o, memr_n_o, memw_n_o, cmd_oe_o, smemr_n_o, smemw_n_o, addr_oe_o, bale_o, aen_o;
	logic         backplane_clk_o, bus_size_sixteen_n_o, hold_request_out_o, dma_wide_o, cycle_done_o, cycle_wide_o;
	logic         int_o, nmi_o, cpu_reset_out_o, fpu_reset_out_o, bios_rom_select_o, speaker_out_o, timer_tick_o;
	logic         cpu_mode_legacy_o, iochrdy_i, zero_wait_n_i, iocs16_n_i, memcs16_n_i, ior_n_i, iow_n_i, memr_n_i, memw_n_i;
	logic [19:0]  sys_addr_o;
	logic [23:17] lat_addr_o;
	logic [3:0]   master_cmd_o, int_vec_o;
	logic [6:0]   seen;
	logic         rom_seen;
	int           errors = 0, n_compared = 0, k, dur, dur_b, ticks = 0;
	// command lines are shared wires: released ones float high on the pull-ups
	assign ior_n_i = cmd_oe_o ? ior_n_o : 1'b1;
	assign iow_n_i = cmd_oe_o ? iow_n_o : 1'b1;
	assign memr_n_i = cmd_oe_o ? memr_n_o : 1'b1;
	assign memw_n_i = cmd_oe_o ? memw_n_o : 1'b1;
	assign memcs16_n_i = iocs16_n_i;
	ibc_cycle_ctrl i_ibc_cycle_ctrl (.clk_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
		.cyc_start_i, .host_mem_i, .host_wr_i, .host_addr_i, .host_byte_enables_n_i, .host_local_i, .host_hold_ack_i,
		.refresh_req_i, .shutdown_i, .timer2_out_i, .int_ack_i, .keyboard_addr20_clamp_n_i, .parity_n_i, .iochk_n_i,
		.iochrdy_i, .zero_wait_n_i, .iocs16_n_i, .memcs16_n_i, .master_n_i, .kbd_reset_req_n_i, .rtc_select_cpu_strap_i,
		.osc_i, .ior_n_i, .iow_n_i, .memr_n_i, .memw_n_i, .drq_i, .irq_hi_i, .irq_lo_i, .rtc_irq_n_i, .ior_n_o, .iow_n_o,
		.memr_n_o, .memw_n_o, .cmd_oe_o, .smemr_n_o, .smemw_n_o, .sys_addr_o, .lat_addr_o, .addr_oe_o, .bale_o, .aen_o,
		.backplane_clk_o, .bus_size_sixteen_n_o, .hold_request_out_o, .dack_n_o, .dma_wide_o, .master_cmd_o,
		.cycle_done_o, .cycle_wide_o, .int_o, .int_vec_o, .nmi_o, .cpu_reset_out_o, .fpu_reset_out_o,
		.bios_rom_select_o, .speaker_out_o, .timer_tick_o, .cpu_mode_legacy_o);
	ibc_card i_ibc_card (.clk_i, .ior_n_i, .iow_n_i, .memr_n_i, .memw_n_i, .wait_i(wait_n), .wide_i(wide),
		.fast_i(fast), .iochrdy_o(iochrdy_i), .cs16_n_o(iocs16_n_i), .zws_n_o(zero_wait_n_i));
	initial forever #50 clk_i = ~clk_i;
	initial forever #35 osc_i = ~osc_i;
	always @(posedge clk_i) begin
		if (timer_tick_o === 1'b1) ticks++;
	end
	task automatic final_report;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic timeout;
		errors++;
		final_report();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		`CHK(reg_rdata_o, e)
	endtask
	task automatic do_reset(input logic s);
		@(posedge clk_i);
		reset_i <= 1'b1;
		rtc_select_cpu_strap_i <= s;
		tick(10);
		`CHK({cpu_reset_out_o, bus_size_sixteen_n_o, dack_n_o}, 10'h3FF)
		@(posedge clk_i);
		reset_i <= 1'b0;
		`WAIT(cpu_reset_out_o === 1'b0)
		tick(3);
		`CHK(cpu_mode_legacy_o, s)
	endtask
	// kind 0 host cycle, 1 local-bus claimed, 2 refresh
	task automatic cyc(input logic [1:0] t, input logic m, input logic w, input logic [31:0] a, input logic [6:0] e);
		@(posedge clk_i);
		cyc_start_i <= (t != 2'h2);
		refresh_req_i <= (t == 2'h2);
		host_local_i <= (t == 2'h1);
		host_mem_i <= m;
		host_wr_i <= w;
		host_addr_i <= a;
		seen = '0;
		rom_seen = 1'b0;
		for (dur = 0; dur < 60; dur++) begin
			@(posedge clk_i);
			cyc_start_i <= 1'b0;
			refresh_req_i <= 1'b0;
			#1;
			seen |= {~bus_size_sixteen_n_o, bale_o, aen_o, ~smemr_n_o, ~memr_n_o, ~iow_n_o, ~ior_n_o};
			rom_seen |= bios_rom_select_o;
			if (cycle_done_o === 1'b1 || (t == 2'h1 && dur == 8)) break;
		end
		`CHK(seen, e)
		if (dur == 60) timeout();
	endtask
	initial begin
		{reg_wr_i, reg_rd_i, cyc_start_i, host_mem_i, host_wr_i, host_local_i, host_hold_ack_i, refresh_req_i} = '0;
		{timer2_out_i, int_ack_i, reg_addr_i, reg_wdata_i, drq_i, wait_n, host_addr_i, irq_hi_i, irq_lo_i} = '0;
		{wide, fast} = '0;
		{reset_i, keyboard_addr20_clamp_n_i, parity_n_i, iochk_n_i, master_n_i, kbd_reset_req_n_i, rtc_irq_n_i} = '1;
		rtc_select_cpu_strap_i = 1'b1;
		do_reset(1'b1);
		rd(REG_CFG, 8'h00);
		rd(REG_SYSCTL, 8'h00);
		rd(REG_NMIMSK, 8'h01);
		rd(8'h55, 8'h00);
		wait_n <= 8'h04;
		wide <= 1'b1;
		cyc(2'h0, 1'b0, 1'b0, 32'h00000300, 7'h61);
		`CHK({cycle_wide_o, sys_addr_o}, 21'h100302)
		dur_b = dur;
		wait_n <= 8'h00;
		wide <= 1'b0;
		cyc(2'h0, 1'b0, 1'b1, 32'h00000300, 7'h62);
		`CHK({cycle_wide_o, dur < dur_b}, 2'h1)
		// the pin sync hides a cut on an unstretched cycle, so zero wait must beat a slow card
		wait_n <= 8'h04;
		fast <= 1'b1;
		cyc(2'h0, 1'b0, 1'b0, 32'h00000300, 7'h61);
		`CHK(dur < dur_b, 1'b1)
		fast <= 1'b0;
		wait_n <= 8'h00;
		cyc(2'h1, 1'b0, 1'b1, 32'h00000300, 7'h00);
		cyc(2'h0, 1'b1, 1'b0, 32'h000C0000, 7'h6C);
		cyc(2'h0, 1'b1, 1'b0, 32'h00100000, 7'h64);
		`CHK(lat_addr_o[20], 1'b1)
		keyboard_addr20_clamp_n_i <= 1'b0;
		tick(2);
		cyc(2'h0, 1'b1, 1'b0, 32'h00100000, 7'h6C);
		`CHK(lat_addr_o[20], 1'b0)
		keyboard_addr20_clamp_n_i <= 1'b1;
		cyc(2'h2, 1'b1, 1'b0, 32'h00000000, 7'h3C);
		timer2_out_i <= 1'b1;
		wr(REG_SYSCTL, 8'h02);
		rd(REG_SYSCTL, 8'h02);
		`CHK(speaker_out_o, 1'b1)
		wr(REG_SYSCTL, 8'h00);
		tick(2);
		`CHK(speaker_out_o, 1'b0)
		wr(REG_CFG, 8'h10);
		cyc(2'h0, 1'b1, 1'b1, 32'h000F0000, 7'h60);
		`CHK(rom_seen, 1'b1)
		wr(REG_CFG, 8'h00);
		cyc(2'h0, 1'b1, 1'b1, 32'h000F0000, 7'h60);
		`CHK(rom_seen, 1'b0)
		cyc(2'h0, 1'b1, 1'b0, 32'h000F0000, 7'h6C);
		`CHK(rom_seen, 1'b1)
		drq_i <= 8'h22;
		`WAIT(hold_request_out_o === 1'b1)
		@(posedge clk_i);
		host_hold_ack_i <= 1'b1;
		`WAIT(dack_n_o !== 8'hFF)
		`CHK({dack_n_o, aen_o, dma_wide_o, hold_request_out_o}, 11'h7ED)
		@(posedge clk_i);
		drq_i <= 8'h20;
		`WAIT(dack_n_o === 8'hDF)
		`CHK(dma_wide_o, 1'b1)
		@(posedge clk_i);
		drq_i <= 8'h00;
		`WAIT(hold_request_out_o === 1'b0)
		@(posedge clk_i);
		host_hold_ack_i <= 1'b0;
		irq_lo_i <= 5'h01;
		irq_hi_i <= 7'h08;
		`WAIT(int_o === 1'b1)
		tick(1);
		`CHK(int_vec_o, 4'hC)
		int_ack_i <= 1'b1;
		@(posedge clk_i);
		int_ack_i <= 1'b0;
		tick(2);
		`CHK(int_vec_o, 4'h3)
		rtc_irq_n_i <= 1'b0;
		`WAIT(int_vec_o === 4'h8)
		@(posedge clk_i);
		parity_n_i <= 1'b0;
		@(posedge clk_i);
		parity_n_i <= 1'b1;
		tick(6);
		`CHK(nmi_o, 1'b0)
		wr(REG_NMIMSK, 8'h00);
		parity_n_i <= 1'b0;
		@(posedge clk_i);
		parity_n_i <= 1'b1;
		`WAIT(nmi_o === 1'b1)
		wr(REG_FASTRST, 8'h01);
		`WAIT(cpu_reset_out_o === 1'b1)
		`CHK(fpu_reset_out_o, 1'b1)
		`WAIT(cpu_reset_out_o === 1'b0)
		kbd_reset_req_n_i <= 1'b0;
		`WAIT(cpu_reset_out_o === 1'b1)
		kbd_reset_req_n_i <= 1'b1;
		`WAIT(cpu_reset_out_o === 1'b0)
		`CHK(ticks > 0 && ticks < k + 60, 1'b1)
		do_reset(1'b0);
		final_report();
	end
endmodule // isa_backplane_cycle_control_tb
